// ### bench/tb_top.sv
/*
 * self-checking bench: apb master, engine stand-in, memory model.
 * assumes the checker is bound to the design by its own file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "twm_consts.svh"

module tb_top;
   import twm_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rdv;
   logic pready, pslverr, errv, tx_valid, fetch_busy, irq;
   logic txn_start = 0, txn_end = 0, tx_ready = 0;
   logic [6:0] slave_addr;
   logic [7:0] tx_data;
   logic [3:0] dly = '0;
   logic [3:0] pstrb = 4'hf;
   twm_byte_res_t byte_res = '0;
   twm_mem_req_t mem_req;
   twm_mem_rsp_t mem_rsp;
   int errors = 0, cmp_count = 0, cyc = 0;
   twm_txdma_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .txn_start,
      .txn_end, .byte_res, .slave_addr, .tx_valid, .tx_data, .tx_ready,
      .fetch_busy, .mem_req, .mem_rsp, .irq);
   twm_mem_model mem (.pclk, .presetn, .dly, .mem_req, .mem_rsp);
   initial forever #5 pclk = ~pclk;
   // ---------------------------------
   // shared tasks
   // ---------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {20'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, '0);
      chk(rdv, e);
   endtask
   task txn(input logic [9:0] lim, input logic [31:0] base, input int nk);
      int i, n, cnt;
      logic [7:0] a;
      cnt = 0;
      apb(1, `TWM_OFS_TX_LIMIT, {22'h0, lim});
      txn_start <= 1;
      @(posedge pclk);
      txn_start <= 0;
      for (i = 0; i < lim; i++)
      begin
         n = 0;
         do
         begin
            @(posedge pclk);
            n++;
         end
         while (tx_valid !== 1 && n < 60);
         chk(tx_valid, 1);
         a = base[7:0] + i[7:0];
         chk({24'h0, tx_data}, {24'h0, a ^ 8'h5a});
         tx_ready <= 1;
         @(posedge pclk);
         // the engine reports a byte once it has left the wire
         tx_ready <= 0;
         byte_res <= {1'b1, i == nk};
         @(posedge pclk);
         byte_res <= '0;
         cnt++;
         if (i == nk)
            break;
      end
      repeat (2) @(posedge pclk);
      repeat (8)
      begin
         @(posedge pclk);
         chk(tx_valid, 0);
      end
      txn_end <= 1;
      @(posedge pclk);
      txn_end <= 0;
      @(posedge pclk);
      rd(`TWM_OFS_TX_COUNT, cnt);
   endtask
   // ---------------------------------
   // scenarios
   // ---------------------------------
   task t_regs;
      logic [11:0] ofs [7] = '{12'h544, 12'h548, 12'h54c, 12'h550,
         12'h588, 12'h600, 12'h604};
      foreach (ofs[k]) rd(ofs[k], 32'h0);
      rd(12'h500, 32'h0);
      chk(errv, 1);
      apb(1, `TWM_OFS_TX_COUNT, 32'h0000_0055);
      chk(errv, 1);
      rd(`TWM_OFS_TX_COUNT, 32'h0);
      $display("test regs done");
   endtask
   task t_fields;
      apb(1, `TWM_OFS_TX_LIMIT, 32'hffff_ffff);
      rd(`TWM_OFS_TX_LIMIT, 32'h0000_03ff);
      pstrb <= 4'h1;
      apb(1, `TWM_OFS_TX_LIMIT, 32'h0000_0000);
      pstrb <= 4'hf;
      rd(`TWM_OFS_TX_LIMIT, 32'h0000_0300);
      apb(1, `TWM_OFS_ADDR, 32'hffff_ffa5);
      chk(slave_addr, 7'h25);
      $display("test fields done");
   endtask
   task t_list;
      apb(1, `TWM_OFS_TX_PTR, 32'h0000_1000);
      txn(3, 32'h1000, 9);
      txn(3, 32'h1000, 9);
      apb(1, `TWM_OFS_TX_LIST, 32'h1);
      dly <= 4'h5;
      txn(2, 32'h1000, 9);
      txn(2, 32'h1002, 9);
      $display("test list done");
   endtask
   task t_nack;
      apb(1, `TWM_OFS_TX_LIST, 32'h0);
      apb(1, `TWM_OFS_TX_PTR, 32'h0000_2000);
      txn(4, 32'h2000, 1);
      rd(`TWM_OFS_INT_STAT, 32'h7);
      chk(irq, 0);
      apb(1, `TWM_OFS_INT_MASK, 32'h2);
      chk(irq, 1);
      apb(1, `TWM_OFS_INT_STAT, 32'h2);
      rd(`TWM_OFS_INT_STAT, 32'h5);
      chk(irq, 0);
      txn(0, 32'h2000, 9);
      $display("test nack and zero done");
   endtask
   // ---------------------------------
   // run control
   // ---------------------------------
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         $display("[ERR] %0t run did not end", $time);
         tally_and_finish;
      end
   end
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_regs;
      t_fields;
      t_list;
      t_nack;
      tally_and_finish;
   end
endmodule // tb_top

`default_nettype wire

// ### bench/twm_mem_model.sv
/*
 * memory behind the fetcher: one ack pulse a request, dly+1 cycles after it is raised,
 * data = address low byte xor 8'h5a.
 * assumes requests are held until answered.
 */
`timescale 1ns/1ps
`default_nettype none

module twm_mem_model
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // answer delay
   input wire logic [3:0] dly,
   // memory port
   input wire twm_pkg::twm_mem_req_t mem_req,
   output twm_pkg::twm_mem_rsp_t mem_rsp
);
   import twm_pkg::*;
   logic [3:0] wait_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         wait_q <= '0;
         mem_rsp <= '0;
      end
      else
      begin
         mem_rsp.ack <= 1'b0;
         // data is inverted every cycle outside an ack, so the byte does not stay steady
         mem_rsp.data <= ~mem_rsp.data;
         if (mem_req.req && !mem_rsp.ack)
         begin
            wait_q <= (wait_q >= dly) ? 4'h0 : wait_q + 4'h1;
            if (wait_q >= dly)
            begin
               mem_rsp.ack <= 1'b1;
               mem_rsp.data <= mem_req.addr[7:0] ^ 8'h5a;
            end
         end
      end
endmodule // twm_mem_model

`default_nettype wire

// ### bench/twm_txdma_regs_chk.sv
/*
 * checker for the transmit buffer control block, bound to its top.
 * assumes byte offsets decode on paddr[11:0] and one pclk domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "twm_consts.svh"

module twm_chk
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pslverr,
   // engine and memory
   input wire logic txn_start,
   input wire twm_pkg::twm_byte_res_t byte_res,
   input wire logic [`TWM_SLV_W-1:0] slave_addr,
   input wire logic fetch_busy,
   input wire twm_pkg::twm_mem_req_t mem_req,
   input wire twm_pkg::twm_mem_rsp_t mem_rsp
);
   import twm_pkg::*;
   // ---------------------------------
   // shadow of limit, fetch counter
   // ---------------------------------
   logic [9:0] lim_q, lat_q, fet_q;
   wire logic acc = psel && penable;
   wire logic wr_lim = acc && pwrite && paddr[11:0] == `TWM_OFS_TX_LIMIT;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         lim_q <= '0;
         lat_q <= '0;
         fet_q <= '0;
      end
      else
      begin
         if (wr_lim && pstrb[0]) lim_q[7:0] <= pwdata[7:0];
         if (wr_lim && pstrb[1]) lim_q[9:8] <= pwdata[9:8];
         // limit taken live at start, like the fetcher
         if (txn_start) lat_q <= lim_q;
         if (txn_start) fet_q <= '0;
         else if (mem_rsp.ack) fet_q <= fet_q + 10'h001;
      end
   // ---------------------------------
   // properties
   // ---------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr_addr;
      acc && pwrite && paddr[11:0] == `TWM_OFS_ADDR && pstrb[0];
   endsequence
   sequence s_start_zero;
      txn_start && lim_q == 10'h000;
   endsequence
   property p_addr;
      s_wr_addr |=> slave_addr == $past(pwdata[6:0]);
   endproperty
   a_addr: assert property (p_addr)
      else $error("target address differs from write");
   property p_lim;
      fet_q <= lat_q;
   endproperty
   a_lim: assert property (p_lim)
      else $error("more bytes fetched than the limit");
   property p_go;
      txn_start && lim_q != 10'h000 && !fetch_busy |=> mem_req.req;
   endproperty
   a_go: assert property (p_go)
      else $error("no fetch after start");
   property p_zero;
      s_start_zero |=> (!mem_req.req) [*4];
   endproperty
   a_zero: assert property (p_zero)
      else $error("fetch with zero limit");
   property p_hold;
      mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable(mem_req.addr);
   endproperty
   a_hold: assert property (p_hold)
      else $error("memory request dropped before answer");
   property p_ro;
      acc && pwrite && paddr[11:0] == `TWM_OFS_TX_COUNT |-> pslverr;
   endproperty
   a_ro: assert property (p_ro)
      else $error("write to count not refused");
   property p_nack;
      byte_res.done && byte_res.nack |-> ##[1:8] !fetch_busy;
   endproperty
   a_nack: assert property (p_nack)
      else $error("fetcher runs on after rejected byte");
endmodule // twm_chk

bind twm_txdma_regs twm_chk u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .txn_start, .byte_res,
   .slave_addr, .fetch_busy, .mem_req, .mem_rsp);

`default_nettype wire

// ### hdl/twm_consts.svh
/*
 * register offsets, field positions, reset values and event bits of the
 * transmit buffer control block.
 * assumes byte addressing on a 32-bit register bus.
 */
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TWM_OFS_TX_PTR 12'h544
`define TWM_OFS_TX_LIMIT 12'h548
`define TWM_OFS_TX_COUNT 12'h54c
`define TWM_OFS_TX_LIST 12'h550
`define TWM_OFS_ADDR 12'h588
`define TWM_OFS_INT_STAT 12'h600
`define TWM_OFS_INT_MASK 12'h604
`define TWM_ADDR_BITS 12

// ----------------------------------------
// field layout
// ----------------------------------------
`define TWM_CNT_W 10
`define TWM_CNT_MAX 10'h3ff
`define TWM_SLV_W 7
`define TWM_EV_W 3
`define TWM_EV_DONE 0
`define TWM_EV_NACK 1
`define TWM_EV_START 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define TWM_RST_WORD 32'h0000_0000
`define TWM_RST_CNT 10'h000
`define TWM_RST_SLV 7'h00
`define TWM_RST_EV 3'h0

`endif

// ### hdl/twm_fetch.sv
/*
 * byte fetcher: reads up to a limit of bytes from memory, one at a time,
 * and offers each to the bus engine with valid and ready.
 * assumes memory answers each request with one ack pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "twm_consts.svh"

module twm_fetch
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic start,
   input wire logic halt,
   input wire logic [`TWM_CNT_W-1:0] limit,
   input wire logic [31:0] base,
   // memory
   output twm_pkg::twm_mem_req_t mem_req,
   input wire twm_pkg::twm_mem_rsp_t mem_rsp,
   // byte stream
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   output logic busy
);
   import twm_pkg::*;

   twm_fetch_state_t state_q, state_d;
   logic [`TWM_CNT_W-1:0] left_q, left_d;
   logic [31:0] addr_q, addr_d;
   logic [7:0] data_q;
   logic stop_q, stop_d;

   wire logic taken = (state_q == twm_offer_s) && tx_ready;
   wire logic got = (state_q == twm_fetch_s) && mem_rsp.ack;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      state_d = state_q;
      left_d = left_q;
      addr_d = addr_q;
      stop_d = stop_q;
      case (state_q)
         twm_idle_s:
            if (start && (limit != `TWM_RST_CNT))
            begin
               // never more than the limit leaves memory
               state_d = twm_fetch_s;
               left_d = limit;
               addr_d = base;
               stop_d = 1'b0;
            end
         twm_fetch_s:
            // an open memory read is answered before going idle
            if (got)
            begin
               stop_d = 1'b0;
               state_d = (halt || stop_q) ? twm_idle_s : twm_offer_s;
            end
            else if (halt)
               stop_d = 1'b1;
         twm_offer_s:
            if (halt)
               state_d = twm_idle_s;
            else if (taken)
            begin
               left_d = left_q - 10'h001;
               addr_d = addr_q + 32'h0000_0001;
               state_d = (left_q == 10'h001) ? twm_idle_s
                                             : twm_fetch_s;
            end
         default:
            state_d = twm_idle_s;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= twm_idle_s;
         left_q <= `TWM_RST_CNT;
         addr_q <= `TWM_RST_WORD;
         data_q <= 8'h00;
         stop_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         left_q <= left_d;
         addr_q <= addr_d;
         stop_q <= stop_d;
         if (got)
            data_q <= mem_rsp.data;
      end
   end

   assign mem_req.req = (state_q == twm_fetch_s);
   assign mem_req.addr = addr_q;
   assign tx_valid = (state_q == twm_offer_s);
   assign tx_data = data_q;
   assign busy = (state_q != twm_idle_s);

endmodule // twm_fetch

`default_nettype wire

// ### hdl/twm_irq.sv
/*
 * sticky event flags with write-one-to-clear and a mask onto one level
 * interrupt.
 * assumes set pulses and clear writes come from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "twm_consts.svh"

module twm_irq
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // events and software
   input wire logic [`TWM_EV_W-1:0] ev_set,
   input wire logic [`TWM_EV_W-1:0] ev_clr,
   input wire logic [`TWM_EV_W-1:0] mask,
   // result
   output logic [`TWM_EV_W-1:0] status,
   output logic irq
);
   import twm_pkg::*;

   logic [`TWM_EV_W-1:0] stat_q;

   // ----------------------------------------
   // per-bit flags
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < `TWM_EV_W; i = i + 1)
      begin : g_flag
         // a set in the clearing cycle wins, so no event is lost
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               stat_q[i] <= 1'b0;
            else if (ev_set[i])
               stat_q[i] <= 1'b1;
            else if (ev_clr[i])
               stat_q[i] <= 1'b0;
         end
      end
   endgenerate

   assign status = stat_q;
   assign irq = |(stat_q & mask);

endmodule // twm_irq

`default_nettype wire

// ### hdl/twm_pkg.sv
/*
 * types shared by the transmit buffer control block.
 * assumes twm_consts.svh is on the include path.
 */
`include "twm_consts.svh"

package twm_pkg;

   // ----------------------------------------
   // list handling
   // ----------------------------------------
   typedef enum logic {
      twm_list_off_e,
      twm_array_list_mode_e
   } twm_list_t;

   // ----------------------------------------
   // fetch engine states
   // ----------------------------------------
   typedef enum logic [1:0] {
      twm_idle_s,
      twm_fetch_s,
      twm_offer_s
   } twm_fetch_state_t;

   // ----------------------------------------
   // memory read request and answer
   // ----------------------------------------
   typedef struct packed {
      logic req;
      logic [31:0] addr;
   } twm_mem_req_t;

   typedef struct packed {
      logic ack;
      logic [7:0] data;
   } twm_mem_rsp_t;

   // ----------------------------------------
   // byte outcome reported by the bus engine
   // ----------------------------------------
   typedef struct packed {
      logic done;
      logic nack;
   } twm_byte_res_t;

endpackage

// ### hdl/twm_txdma_regs.sv
/*
 * transmit buffer control and target address registers of a two-wire
 * master, with an apb slave, a byte fetcher and interrupt flags.
 * assumes the bus engine runs on pclk and reports start, per-byte
 * outcome and end of each transaction as one-cycle pulses.
 */
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "twm_consts.svh"

module twm_txdma_regs
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // bus engine
   input wire logic txn_start,
   input wire logic txn_end,
   input wire twm_pkg::twm_byte_res_t byte_res,
   output logic [`TWM_SLV_W-1:0] slave_addr,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   output logic fetch_busy,
   // memory read port
   output twm_pkg::twm_mem_req_t mem_req,
   input wire twm_pkg::twm_mem_rsp_t mem_rsp,
   // interrupt
   output logic irq
);
   import twm_pkg::*;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic logic hit(input logic [31:0] a,
                                input logic [`TWM_ADDR_BITS-1:0] ofs);
      hit = (a[31:`TWM_ADDR_BITS] == 20'h00000)
         && (a[`TWM_ADDR_BITS-1:0] == ofs);
   endfunction

   wire logic setup_ph = psel && !penable;
   wire logic access_ph = psel && penable;
   wire logic wr_en = access_ph && pwrite && pstrb[0];
   wire logic hit_ptr = hit(paddr, `TWM_OFS_TX_PTR);
   wire logic hit_lim = hit(paddr, `TWM_OFS_TX_LIMIT);
   wire logic hit_cnt = hit(paddr, `TWM_OFS_TX_COUNT);
   wire logic hit_list = hit(paddr, `TWM_OFS_TX_LIST);
   wire logic hit_addr = hit(paddr, `TWM_OFS_ADDR);
   wire logic hit_stat = hit(paddr, `TWM_OFS_INT_STAT);
   wire logic hit_mask = hit(paddr, `TWM_OFS_INT_MASK);
   wire logic mapped = hit_ptr || hit_lim || hit_cnt || hit_list
      || hit_addr || hit_stat || hit_mask;
   // the count register is read only; a write to it is refused
   wire logic bad = !mapped || (pwrite && hit_cnt);

   // byte lanes of a word write, for the wide pointer register
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
      merge = {be[3] ? nw[31:24] : old[31:24],
               be[2] ? nw[23:16] : old[23:16],
               be[1] ? nw[15:8] : old[15:8],
               be[0] ? nw[7:0] : old[7:0]};
   endfunction

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   logic [31:0] ptr_q;
   logic [`TWM_CNT_W-1:0] limit_q;
   twm_list_t list_q;
   logic [`TWM_SLV_W-1:0] slv_q;
   logic [`TWM_EV_W-1:0] mask_q;
   logic [`TWM_CNT_W-1:0] count_q;
   logic [31:0] prdata_q;

   // low-lane fields need only pstrb[0]
   wire logic wr_ptr = access_ph && pwrite && hit_ptr;
   wire logic wr_lim = wr_en && hit_lim;
   wire logic wr_list = wr_en && hit_list;
   wire logic wr_slv = wr_en && hit_addr;
   wire logic wr_stat = wr_en && hit_stat;
   wire logic wr_mask = wr_en && hit_mask;

   // limit upper bits sit in lane 1
   wire logic [`TWM_CNT_W-1:0] lim_wdata = {
      pstrb[1] ? pwdata[9:8] : limit_q[9:8], pwdata[7:0]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         limit_q <= `TWM_RST_CNT;
         list_q <= twm_list_off_e;
         slv_q <= `TWM_RST_SLV;
         mask_q <= `TWM_RST_EV;
      end
      else
      begin
         if (wr_lim)
            limit_q <= lim_wdata;
         if (wr_list)
            list_q <= twm_list_t'(pwdata[0]);
         if (wr_slv)
            slv_q <= pwdata[`TWM_SLV_W-1:0];
         if (wr_mask)
            mask_q <= pwdata[`TWM_EV_W-1:0];
      end
   end

   // ----------------------------------------
   // transaction tracking
   // ----------------------------------------
   logic active_q;
   logic [`TWM_CNT_W-1:0] moved_q;
   logic [`TWM_CNT_W-1:0] run_lim_q;
   logic [31:0] run_ptr_q;
   twm_list_t run_list_q;

   // every finished byte counts, acked or not
   wire logic byte_seen = active_q && byte_res.done;
   wire logic [`TWM_CNT_W-1:0] moved_inc =
      (moved_q == `TWM_CNT_MAX) ? moved_q : moved_q + 10'h001;
   wire logic [`TWM_CNT_W-1:0] moved_now =
      byte_seen ? moved_inc : moved_q;
   wire logic ended = active_q && txn_end;
   // next buffer of the array follows straight after this one
   wire logic [31:0] next_ptr =
      run_ptr_q + {22'h000000, run_lim_q};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         active_q <= 1'b0;
         moved_q <= `TWM_RST_CNT;
         count_q <= `TWM_RST_CNT;
         run_lim_q <= `TWM_RST_CNT;
         run_ptr_q <= `TWM_RST_WORD;
         run_list_q <= twm_list_off_e;
      end
      else
      begin
         if (txn_start)
         begin
            // limit, pointer and list mode are latched so writes to them mid-transaction are safe
            active_q <= 1'b1;
            moved_q <= `TWM_RST_CNT;
            run_lim_q <= limit_q;
            run_ptr_q <= ptr_q;
            run_list_q <= list_q;
         end
         else if (ended)
         begin
            active_q <= 1'b0;
            moved_q <= `TWM_RST_CNT;
            count_q <= moved_now;
         end
         else
            moved_q <= moved_now;
      end
   end

   // ----------------------------------------
   // buffer pointer with list advance
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ptr_q <= `TWM_RST_WORD;
      else if (wr_ptr)
         ptr_q <= merge(ptr_q, pwdata, pstrb);
      else if (ended && (run_list_q == twm_array_list_mode_e))
         ptr_q <= next_ptr;
   end

   // ----------------------------------------
   // byte fetcher
   // ----------------------------------------
   // a refused byte ends the fetch; the engine then closes the frame
   wire logic halt = ended || (byte_seen && byte_res.nack);

   twm_fetch u_fetch
   (
      .pclk(pclk),
      .presetn(presetn),
      .start(txn_start),
      .halt(halt),
      .limit(limit_q),
      .base(ptr_q),
      .mem_req(mem_req),
      .mem_rsp(mem_rsp),
      .tx_valid(tx_valid),
      .tx_data(tx_data),
      .tx_ready(tx_ready),
      .busy(fetch_busy)
   );

   // ----------------------------------------
   // interrupt flags
   // ----------------------------------------
   logic [`TWM_EV_W-1:0] ev_set;
   logic [`TWM_EV_W-1:0] status;

   always_comb
   begin
      ev_set = `TWM_RST_EV;
      ev_set[`TWM_EV_DONE] = ended;
      ev_set[`TWM_EV_NACK] = byte_seen && byte_res.nack;
      ev_set[`TWM_EV_START] = txn_start;
   end

   twm_irq u_irq
   (
      .pclk(pclk),
      .presetn(presetn),
      .ev_set(ev_set),
      .ev_clr(wr_stat ? pwdata[`TWM_EV_W-1:0] : `TWM_RST_EV),
      .mask(mask_q),
      .status(status),
      .irq(irq)
   );

   // ----------------------------------------
   // read data, captured in setup for a zero-wait answer
   // ----------------------------------------
   logic [31:0] rd_mux;

   always_comb
   begin
      rd_mux = `TWM_RST_WORD;
      if (hit_ptr)
         rd_mux = ptr_q;
      else if (hit_lim)
         rd_mux = {22'h000000, limit_q};
      else if (hit_cnt)
         rd_mux = {22'h000000, count_q};
      else if (hit_list)
         rd_mux = {31'h00000000, list_q};
      else if (hit_addr)
         rd_mux = {25'h0000000, slv_q};
      else if (hit_stat)
         rd_mux = {29'h00000000, status};
      else if (hit_mask)
         rd_mux = {29'h00000000, mask_q};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= `TWM_RST_WORD;
      else if (setup_ph && !pwrite)
         prdata_q <= rd_mux;
   end

   // ----------------------------------------
   // apb response and engine outputs
   // ----------------------------------------
   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = access_ph && bad;
   assign slave_addr = slv_q;

endmodule // twm_txdma_regs

`default_nettype wire
